// >>> tpf_pkg.sv
// Constants, format-entry layout and timing for the telemetry polling formatter.
// Assumes a single 250 MHz system clock; all rates are derived from it.
package tpf_pkg;

	// System clock and output bit rates
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned BIT_HZ_LOW = 64_000;
	localparam int unsigned BIT_HZ_HIGH = 128_000;
	localparam logic [11:0] DIV_LOW = 12'(CLK_HZ / BIT_HZ_LOW);
	localparam logic [11:0] DIV_HIGH = 12'(CLK_HZ / BIT_HZ_HIGH);

	// Frame geometry
	localparam int unsigned WORD_W = 16;
	localparam logic [3:0] WORD_LAST_BIT = 4'hf;
	localparam int unsigned FMT_DEPTH = 64;
	localparam logic [5:0] SLOT_LAST = 6'h3f;

	// Slots without an external sync before own timing takes over
	localparam logic [7:0] SYNC_LOSS_SLOTS = 8'h80;

	// Multiplexer units polled: four forward, three aft
	localparam int unsigned MUX_UNITS = 7;
	localparam logic [2:0] MUX_UNIT_LAST = 3'h6;
	localparam int unsigned STORE_DEPTH = 64;

	// Format entry: [15:14] source, [13:11] unit, [10:8] channel, [0] rate in slot 0
	localparam int unsigned SRC_HI = 15;
	localparam int unsigned SRC_LO = 14;
	localparam int unsigned UNIT_HI = 13;
	localparam int unsigned UNIT_LO = 11;
	localparam int unsigned CHAN_HI = 10;
	localparam int unsigned CHAN_LO = 8;
	localparam int unsigned RATE_BIT = 0;

	// Word sources
	typedef enum logic [1:0] {
		TPF_SRC_MUX = 2'h0,
		TPF_SRC_COMPUTER = 2'h1,
		TPF_SRC_PAYLOAD = 2'h2,
		TPF_SRC_FILL = 2'h3
	} tpf_src_e;

	// Filler word and latest-value store read addresses beyond the mux words
	localparam logic [15:0] FILL_WORD = 16'ha5a5;
	localparam logic [6:0] RD_ADDR_COMPUTER = 7'h40;
	localparam logic [6:0] RD_ADDR_PAYLOAD = 7'h41;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;

	// Fixed format: mux, computer, mux, payload repeating; 64 kbps
	function automatic logic [15:0] tpf_rom_entry(input logic [5:0] idx);
		logic [15:0] e;
		logic [2:0] unit;
		e = 16'h0000;
		unit = 3'((idx >> 2) % MUX_UNITS);
		unique case (idx[1:0])
			2'h0, 2'h2: e[SRC_HI:SRC_LO] = TPF_SRC_MUX;
			2'h1: e[SRC_HI:SRC_LO] = TPF_SRC_COMPUTER;
			2'h3: e[SRC_HI:SRC_LO] = TPF_SRC_PAYLOAD;
		endcase
		e[UNIT_HI:UNIT_LO] = unit;
		e[CHAN_HI:CHAN_LO] = {idx[5], idx[2], idx[1]};
		return e;
	endfunction

endpackage

// >>> tpf_timing.sv
// Bit, word and frame timing for the telemetry polling formatter.
// Assumes ext_sync is a one-cycle frame pulse already synchronous to clk.
`timescale 1ns/1ns
module tpf_timing
	import tpf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic rate_128,
	input wire logic ext_sync,
	// Timing pulses
	output logic bit_en,
	output logic word_start,
	output logic frame_start,
	output logic [5:0] slot,
	output logic own_timing
);

	typedef struct packed {
		logic [11:0] div;
		logic [3:0] bit_cnt;
		logic [5:0] slot;
		logic [7:0] miss;
		logic own;
	} tpf_tim_s;

	tpf_tim_s st_q, st_d;
	logic tick;

	// Bit period ends on the divider's terminal count
	assign tick = (st_q.div == ((rate_128 ? DIV_HIGH : DIV_LOW) - 12'h001));

	// Free-running counters, re-aligned by the external frame sync
	always_comb begin
		st_d = st_q;
		st_d.div = tick ? 12'h000 : st_q.div + 12'h001;
		if (tick) begin
			st_d.bit_cnt = st_q.bit_cnt + 4'h1;
			if (st_q.bit_cnt == WORD_LAST_BIT) begin
				st_d.slot = st_q.slot + 6'h01;
				// Count slots without sync; fall back to own timing
				if (st_q.miss == SYNC_LOSS_SLOTS) begin
					st_d.own = 1'b1;
				end else begin
					st_d.miss = st_q.miss + 8'h01;
				end
			end
		end
		if (ext_sync) begin
			// Force the next cycle to open a fresh frame
			st_d.div = (rate_128 ? DIV_HIGH : DIV_LOW) - 12'h001;
			st_d.bit_cnt = WORD_LAST_BIT;
			st_d.slot = SLOT_LAST;
			st_d.miss = 8'h00;
			st_d.own = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Pulses mark the first bit of a word and of a frame
	assign bit_en = tick;
	assign word_start = tick && (st_q.bit_cnt == WORD_LAST_BIT);
	assign frame_start = word_start && (st_q.slot == SLOT_LAST);
	assign slot = st_q.slot + 6'h01;
	assign own_timing = st_q.own;

endmodule // tpf_timing

// >>> tpf_formatter.sv
// Telemetry master formatter: polls mux units, interleaves sources, serialises the frame.
// Assumes all inputs synchronous to sys_clk and mux answers as one-cycle parallel words.
`timescale 1ns/1ns
module tpf_formatter
	import tpf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Redundancy
	input wire logic unit_active,
	input wire logic unit_second,
	// Master timing
	input wire logic ext_sync,
	output logic own_timing,
	output logic ilv_sync,
	output logic net_sync,
	// Mux unit polling
	output logic mux_req,
	output logic mux_port_primary,
	output logic mux_port_secondary,
	output logic [2:0] mux_unit,
	output logic [2:0] mux_chan,
	input wire logic mux_resp_valid,
	input wire logic [15:0] mux_resp_data,
	// Computer downlist and payload words
	input wire logic [15:0] computer_data,
	input wire logic [15:0] payload_data,
	// Format memory load
	input wire logic fmt_wr_en,
	input wire logic [5:0] fmt_wr_addr,
	input wire logic [15:0] fmt_wr_data,
	input wire logic fmt_use_ram,
	input wire logic fmt_use_rom,
	output logic fmt_ram_active,
	// Latest-value read by a flight computer
	input wire logic rd_req,
	input wire logic [6:0] rd_addr,
	output logic rd_valid,
	output logic [15:0] rd_data,
	// Stream to the network signal processor
	output logic net_data,
	output logic net_bit_en,
	output logic net_frame
);

	typedef struct packed {
		logic use_ram;
		logic rate_128;
		logic [15:0] shift;
		logic pending;
		logic [5:0] poll_addr;
		logic mux_req;
		logic [2:0] mux_unit;
		logic [2:0] mux_chan;
		logic [15:0] comp_last;
		logic [15:0] pay_last;
		logic rd_valid;
		logic [15:0] rd_data;
		logic net_data;
		logic net_bit_en;
		logic net_frame;
		logic sync;
	} tpf_top_s;

	tpf_top_s st_q, st_d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [15:0] fmt_ram [FMT_DEPTH];
	logic [15:0] store [STORE_DEPTH];
	logic bit_en, word_start, frame_start;
	logic [5:0] slot;
	logic [15:0] cur_entry, nxt_entry, cur_word;
	logic [5:0] cur_addr;
	logic store_we;

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Bit, word and frame timing with sync-loss fallback
	tpf_timing u_timing (
		.clk(sys_clk),
		.rst_n(rst_n),
		.rate_128(st_q.rate_128),
		.ext_sync(ext_sync),
		.bit_en(bit_en),
		.word_start(word_start),
		.frame_start(frame_start),
		.slot(slot),
		.own_timing(own_timing)
	);

	// Rewritable format memory
	always_ff @(posedge sys_clk) begin
		if (fmt_wr_en) begin
			fmt_ram[fmt_wr_addr] <= fmt_wr_data;
		end
	end

	// Format entries for this slot and the next; fixed one unless RAM selected
	assign cur_entry = st_q.use_ram ? fmt_ram[slot] : tpf_rom_entry(slot);
	assign nxt_entry = st_q.use_ram ? fmt_ram[slot + 6'h01] : tpf_rom_entry(slot + 6'h01);
	assign cur_addr = {cur_entry[UNIT_HI:UNIT_LO], cur_entry[CHAN_HI:CHAN_LO]};

	// Word for the current slot, chosen by its source field
	always_comb begin
		unique case (tpf_src_e'(cur_entry[SRC_HI:SRC_LO]))
			TPF_SRC_MUX: cur_word = (cur_entry[UNIT_HI:UNIT_LO] <= MUX_UNIT_LAST) ?
				store[cur_addr] : FILL_WORD;
			TPF_SRC_COMPUTER: cur_word = computer_data;
			TPF_SRC_PAYLOAD: cur_word = payload_data;
			TPF_SRC_FILL: cur_word = FILL_WORD;
		endcase
	end

	// Store mux answers for the poll outstanding
	assign store_we = st_q.pending && mux_resp_valid;
	always_ff @(posedge sys_clk) begin
		if (store_we) begin
			store[st_q.poll_addr] <= mux_resp_data;
		end
	end

	// Sequencing of polls, serial output and store reads
	always_comb begin
		st_d = st_q;
		st_d.mux_req = 1'b0;
		st_d.rd_valid = 1'b0;
		st_d.net_bit_en = 1'b0;
		st_d.net_frame = 1'b0;
		st_d.sync = 1'b0;
		// Format memory choice; fixed is the power-up state
		if (fmt_use_ram) begin
			st_d.use_ram = 1'b1;
		end else if (fmt_use_rom) begin
			st_d.use_ram = 1'b0;
		end
		if (store_we) begin
			st_d.pending = 1'b0;
		end
		// Sync pulses continue on own timing as well
		st_d.sync = frame_start;
		if (frame_start) begin
			st_d.rate_128 = cur_entry[RATE_BIT];
		end
		if (bit_en) begin
			st_d.net_bit_en = unit_active;
			st_d.net_data = unit_active & st_q.shift[WORD_W-1];
			st_d.shift = {st_q.shift[WORD_W-2:0], 1'b0};
		end
		if (word_start) begin
			st_d.net_frame = unit_active & frame_start;
			st_d.net_data = unit_active & cur_word[WORD_W-1];
			st_d.shift = {cur_word[WORD_W-2:0], 1'b0};
			if (tpf_src_e'(cur_entry[SRC_HI:SRC_LO]) == TPF_SRC_COMPUTER) begin
				st_d.comp_last = computer_data;
			end
			if (tpf_src_e'(cur_entry[SRC_HI:SRC_LO]) == TPF_SRC_PAYLOAD) begin
				st_d.pay_last = payload_data;
			end
			// Poll one slot ahead; an unanswered poll is dropped here
			st_d.pending = 1'b0;
			if (unit_active && tpf_src_e'(nxt_entry[SRC_HI:SRC_LO]) == TPF_SRC_MUX &&
				nxt_entry[UNIT_HI:UNIT_LO] <= MUX_UNIT_LAST) begin
				st_d.mux_req = 1'b1;
				st_d.pending = 1'b1;
				st_d.mux_unit = nxt_entry[UNIT_HI:UNIT_LO];
				st_d.mux_chan = nxt_entry[CHAN_HI:CHAN_LO];
				st_d.poll_addr = {nxt_entry[UNIT_HI:UNIT_LO], nxt_entry[CHAN_HI:CHAN_LO]};
			end
		end
		// Computer read of the latest values
		if (rd_req) begin
			st_d.rd_valid = 1'b1;
			if (rd_addr == RD_ADDR_COMPUTER) begin
				st_d.rd_data = st_q.comp_last;
			end else if (rd_addr == RD_ADDR_PAYLOAD) begin
				st_d.rd_data = st_q.pay_last;
			end else if (rd_addr < 7'(STORE_DEPTH)) begin
				st_d.rd_data = store[rd_addr[5:0]];
			end else begin
				st_d.rd_data = RD_UNMAPPED;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign ilv_sync = st_q.sync;
	assign net_sync = st_q.sync;
	assign mux_req = st_q.mux_req;
	assign mux_port_primary = st_q.mux_req & ~unit_second;
	assign mux_port_secondary = st_q.mux_req & unit_second;
	assign mux_unit = st_q.mux_unit;
	assign mux_chan = st_q.mux_chan;
	assign fmt_ram_active = st_q.use_ram;
	assign rd_valid = st_q.rd_valid;
	assign rd_data = st_q.rd_data;
	assign net_data = st_q.net_data;
	assign net_bit_en = st_q.net_bit_en;
	assign net_frame = st_q.net_frame;

endmodule // tpf_formatter

// >>> tpf_formatter_asserts.sv
// Port checker for the telemetry polling formatter.
// Assumes it is bound to tpf_formatter and sees only its ports.
`timescale 1ns/1ns
module tpf_formatter_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control inputs
	input wire logic unit_active,
	input wire logic unit_second,
	input wire logic ext_sync,
	input wire logic rd_req,
	input wire logic [6:0] rd_addr,
	// Watched outputs
	input wire logic own_timing,
	input wire logic ilv_sync,
	input wire logic net_sync,
	input wire logic mux_req,
	input wire logic mux_port_primary,
	input wire logic mux_port_secondary,
	input wire logic [2:0] mux_unit,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire logic net_bit_en,
	input wire logic net_frame
);
	// All checks run on the system clock
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_poll_when_active: assert property (mux_req |-> $past(unit_active))
		else $error("poll from an inactive unit");
	a_port_first: assert property (mux_req && !unit_second |->
		mux_port_primary && !mux_port_secondary)
		else $error("unit one poll not on primary port");
	a_port_second: assert property (mux_req && unit_second |->
		mux_port_secondary && !mux_port_primary)
		else $error("unit two poll not on secondary port");
	a_port_needs_req: assert property (!mux_req |->
		!mux_port_primary && !mux_port_secondary)
		else $error("port flag without poll");
	a_unit_range: assert property (mux_req |-> mux_unit <= 3'h6)
		else $error("poll of a unit beyond seven");
	a_poll_spacing: assert property (mux_req |=> !mux_req [*8])
		else $error("polls too close together");
	a_read_answer: assert property (rd_req |=> rd_valid)
		else $error("read not answered next cycle");
	a_read_unmapped: assert property (rd_req && rd_addr > 7'h41 |=> rd_data == 16'h0000)
		else $error("unmapped read not zero");
	a_sync_pair: assert property (ilv_sync && $past(unit_active) |->
		net_sync && net_frame)
		else $error("sync pulses not on the frame marker");
	a_ext_sync_frame: assert property (ext_sync |-> ##[1:3] (ilv_sync && !own_timing))
		else $error("external sync not followed by frame start");
	a_inactive_quiet: assert property (!unit_active && !$past(unit_active) |->
		!net_bit_en)
		else $error("inactive unit drives stream");
endmodule // tpf_formatter_asserts

bind tpf_formatter tpf_formatter_asserts u_chk (.sys_clk, .reset_n, .unit_active, .unit_second,
	.ext_sync, .rd_req, .rd_addr, .own_timing, .ilv_sync, .net_sync, .mux_req, .mux_port_primary,
	.mux_port_secondary, .mux_unit, .rd_valid, .rd_data, .net_bit_en, .net_frame);

// >>> tpf_mux_model.sv
// Behavioural multiplexer unit answering polls of the formatter.
// Assumes polls are one-cycle pulses with unit and channel held after them.
`timescale 1ns/1ns
module tpf_mux_model (
	// Clock and setup
	input wire logic clk,
	input wire logic sel_second,
	input wire logic [7:0] delay,
	// Poll side
	input wire logic port_primary,
	input wire logic port_secondary,
	input wire logic [2:0] unit,
	input wire logic [2:0] chan,
	// Answer side
	output logic resp_valid,
	output logic [15:0] resp_data
);
	initial begin
		resp_valid = 1'b0;
		resp_data = 16'h0000;
	end
	// Answer only a poll on the port of the selected master, then release the bus
	always @(posedge clk) begin
		if (sel_second ? port_secondary : port_primary) begin
			repeat (delay) @(posedge clk);
			resp_valid <= 1'b1;
			resp_data <= {8'hc0, 2'h0, unit, chan};
			@(posedge clk);
			resp_valid <= 1'b0;
			resp_data <= ~resp_data;
		end
	end
endmodule // tpf_mux_model

// >>> tpf_formatter_tb_top.sv
// Self-checking testbench for the telemetry polling formatter.
// Assumes the 250 MHz clock and the fixed format after reset.
`timescale 1ns/1ns
module tpf_formatter_tb_top;
	import tpf_pkg::*;
	logic sys_clk = 0, reset_n = 0, unit_active = 1, second = 0, ext_sync = 0;
	logic fmt_wr_en = 0, fmt_use_ram = 0, fmt_use_rom = 0, rd_req = 0;
	logic [5:0] fmt_wr_addr = 6'h00;
	logic [15:0] fmt_wr_data = 16'h0000, cdata = 16'hb3c6, pdata = 16'h5e21;
	logic [6:0] rd_addr = 7'h00;
	logic [7:0] delay = 8'h01;
	logic own_timing, ilv_sync, net_sync, mux_req, pp, ps, rv, rd_valid, ram_act;
	logic net_data, net_bit_en, net_frame;
	logic [2:0] mux_unit, mux_chan;
	logic [15:0] rdat, rd_data;
	int failures = 0, n_compared = 0;

	// Design and far-side multiplexer unit
	tpf_formatter dut (.sys_clk(sys_clk), .reset_n(reset_n), .unit_active(unit_active),
		.unit_second(second), .ext_sync(ext_sync), .own_timing(own_timing), .ilv_sync(ilv_sync),
		.net_sync(net_sync), .mux_req(mux_req), .mux_port_primary(pp), .mux_port_secondary(ps),
		.mux_unit(mux_unit), .mux_chan(mux_chan), .mux_resp_valid(rv), .mux_resp_data(rdat),
		.computer_data(cdata), .payload_data(pdata), .fmt_wr_en(fmt_wr_en),
		.fmt_wr_addr(fmt_wr_addr), .fmt_wr_data(fmt_wr_data), .fmt_use_ram(fmt_use_ram),
		.fmt_use_rom(fmt_use_rom), .fmt_ram_active(ram_act), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data), .net_data(net_data), .net_bit_en(net_bit_en),
		.net_frame(net_frame));
	tpf_mux_model u_mux (.clk(sys_clk), .sel_second(second), .delay(delay), .port_primary(pp),
		.port_secondary(ps), .unit(mux_unit), .chan(mux_chan), .resp_valid(rv), .resp_data(rdat));

	// Clock generator
	always #2 sys_clk = ~sys_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read strobe stands one edge, then one idle edge before the next call
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge sys_clk);
		chk({15'h0, rd_valid}, 16'h1);
		chk(rd_data, e);
		rd_req = 1'b0;
		@(negedge sys_clk);
	endtask

	// Write strobe stands one edge, then one idle edge before the next call
	task automatic wr_fmt(input logic [5:0] a, input logic [15:0] d);
		fmt_wr_en = 1'b1;
		fmt_wr_addr = a;
		fmt_wr_data = d;
		@(negedge sys_clk);
		fmt_wr_en = 1'b0;
		@(negedge sys_clk);
	endtask

	// Load a one-poll format, sync a frame and read back the answer
	task automatic t_poll(input logic sec, input logic [2:0] u, input logic [2:0] c,
		input logic [7:0] d);
		int i;
		second = sec;
		delay = d;
		wr_fmt(6'h00, 16'h4000);
		wr_fmt(6'h01, {2'h0, u, c, 8'h00});
		// Other slots carry filler so no stray poll or unknown word goes out
		for (i = 2; i < 64; i++) wr_fmt(6'(i), 16'hc000);
		fmt_use_ram = 1'b1;
		@(negedge sys_clk);
		fmt_use_ram = 1'b0;
		@(negedge sys_clk);
		chk({15'h0, ram_act}, 16'h1);
		ext_sync = 1'b1;
		@(negedge sys_clk);
		ext_sync = 1'b0;
		for (i = 0; i < 10 && mux_req !== 1'b1; i++) @(negedge sys_clk);
		chk({13'h0, ps, pp, mux_req}, {13'h0, sec, !sec, 1'b1});
		chk({10'h0, mux_unit, mux_chan}, {10'h0, u, c});
		repeat (30) @(negedge sys_clk);
		rd({1'b0, u, c}, {8'hc0, 2'h0, u, c});
		rd(7'h40, cdata);
		$display("poll test done");
	endtask

	// First bits of a synced frame carry the computer word at the rate slot 0 selects
	task automatic t_stream(input logic r);
		int i, k, n;
		wr_fmt(6'h00, {15'h2000, r});
		ext_sync = 1'b1;
		@(negedge sys_clk);
		ext_sync = 1'b0;
		for (i = 0; i < 8 && net_frame !== 1'b1; i++) @(negedge sys_clk);
		chk({15'h0, net_frame}, 16'h1);
		chk({15'h0, net_data}, {15'h0, cdata[15]});
		for (k = 14; k > 11; k--) begin
			n = 0;
			do begin
				@(negedge sys_clk);
				n++;
			end while (net_bit_en !== 1'b1 && n < 5000);
			chk({15'h0, net_data}, {15'h0, cdata[k]});
			chk(16'(n), r ? 16'(DIV_HIGH) : 16'(DIV_LOW));
		end
		$display("stream test done");
	endtask

	// Inactive unit keeps syncing but never polls nor drives the stream
	task automatic t_inactive();
		logic q, s, b;
		q = 0;
		s = 0;
		b = 0;
		unit_active = 1'b0;
		ext_sync = 1'b1;
		@(negedge sys_clk);
		ext_sync = 1'b0;
		repeat (20) begin
			q = q | (mux_req === 1'b1);
			s = s | ((ilv_sync === 1'b1) & (net_sync === 1'b1));
			b = b | (net_bit_en !== 1'b0);
			@(negedge sys_clk);
		end
		chk({12'h0, net_data, b, q, s}, 16'h1);
		unit_active = 1'b1;
		$display("inactive test done");
	endtask

	// A reset in mid-run brings back the fixed format with own timing off
	task automatic t_reset();
		chk({15'h0, ram_act}, 16'h1);
		reset_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk({14'h0, ram_act, own_timing}, 16'h0);
		$display("reset test done");
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (4) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk({14'h0, ram_act, own_timing}, 16'h0);
		rd(7'h42, 16'h0000);
		t_poll(1'b0, 3'h5, 3'h3, 8'h01);
		t_stream(1'b0);
		t_stream(1'b1);
		t_poll(1'b1, 3'h6, 3'h7, 8'h14);
		t_inactive();
		t_reset();
		end_of_test();
	end

	// Watchdog
	initial begin
		#400_000;
		failures++;
		end_of_test();
	end
endmodule // tpf_formatter_tb_top
